// ### include/rbd_defines.svh
// Offsets, fields, reset values and clock rates for the receive deserialize/order tail
`ifndef RBD_DEFINES_SVH
`define RBD_DEFINES_SVH
`define RBD_REG_CTRL        8'h00
`define RBD_REG_PATTERN     8'h04
`define RBD_REG_PAD         8'h08
`define RBD_REG_STATUS      8'h0C
`define RBD_CTRL_DEC_EN     0
`define RBD_CTRL_DES_EN     1
`define RBD_CTRL_ORD_EN     2
`define RBD_CTRL_DOUBLE     3
`define RBD_CTRL_USER_TRIG  4
`define RBD_CTRL_OC48       5
`define RBD_CTRL_MANUAL_AL  6
`define RBD_CTRL_RST        32'h0000_0002
`define RBD_PATTERN_RST     32'h0000_0000
`define RBD_PAD_RST         32'h0000_0000
`define RBD_OC48_PATTERN    10'h028
`define RBD_OC48_PAD        10'h028
`define RBD_K28_5_CODE      10'h17C
`define RBD_K28_5_BYTE      8'hBC
`define RBD_FABRIC_CEIL_MHZ 250
`define RBD_PCS_MHZ         100
`endif

// ### include/rbd_pkg.sv
// Types shared by the receive deserialize/order tail
package rbd_pkg;
  typedef enum logic [1:0] {
    RBD_IDLE_S   = 2'b00,
    RBD_SEARCH_S = 2'b01,
    RBD_LOCKED_S = 2'b11
  } rbd_ord_state_type;
  typedef logic [9:0] rbd_symbol_type;
endpackage

// ### core/rbd_decoder.sv
// Two-lane code-group decoder with per-byte control flag
`timescale 1ns/1ns
`include "rbd_defines.svh"
module rbd_decoder (
  input  wire logic [19:0] code_in,
  output logic      [15:0] byte_out,
  output logic      [1:0]  ctrl_out
);
  import rbd_pkg::*;
  // Data bits pass straight through from cg[8:6] and cg[4:0]; disparity is not checked here
  function automatic logic [8:0] rbd_dec_lane(input logic [9:0] cg);
    logic [9:0] inv;
    logic [8:0] res;
    inv = ~cg;
    res = {1'b0, cg[7:0]};
    if ((cg == `RBD_K28_5_CODE) || (inv == `RBD_K28_5_CODE)) begin
      res = {1'b1, `RBD_K28_5_BYTE};
    end else if ((cg[9:4] == 6'h0F) || (cg[9:4] == 6'h30)) begin
      res = {1'b1, 3'h0, 5'h1C};
    end else begin
      res = {1'b0, cg[8:6], cg[4:0]};
    end
    return res;
  endfunction
  logic [8:0] lo_w;
  logic [8:0] hi_w;
  always_comb begin
    lo_w = rbd_dec_lane(code_in[9:0]);
    hi_w = rbd_dec_lane(code_in[19:10]);
    byte_out = {hi_w[7:0], lo_w[7:0]};
    ctrl_out = {hi_w[8], lo_w[8]};
  end
endmodule

// ### core/rbd_deser.sv
// Byte deserializer: pairs input words into one double-width word
`timescale 1ns/1ns
module rbd_deser #(
  parameter int W = 20
) (
  input  wire logic           clock,
  input  wire logic           rst_b,
  input  wire logic [W-1:0]   din,
  input  wire logic           din_valid,
  input  wire logic           enable,
  output logic      [2*W-1:0] dout,
  output logic                dout_valid
);
  if (W < 1) begin : g_w_check
    $error("W must be positive");
  end
  logic [W-1:0]   low_r;
  logic [W-1:0]   low_nxt;
  logic           half_r;
  logic           half_nxt;
  logic [2*W-1:0] dout_r;
  logic [2*W-1:0] dout_nxt;
  logic           dv_r;
  logic           dv_nxt;
  always_comb begin
    low_nxt  = low_r;
    half_nxt = half_r;
    dout_nxt = dout_r;
    dv_nxt   = 1'b0;
    if (!enable) begin
      dout_nxt = {{W{1'b0}}, din};
      dv_nxt   = din_valid;
      half_nxt = 1'b0;
    end else if (din_valid) begin
      // First word after reset becomes the low half, whatever it is
      if (!half_r) begin
        low_nxt  = din;
        half_nxt = 1'b1;
      end else begin
        dout_nxt = {din, low_r};
        dv_nxt   = 1'b1;
        half_nxt = 1'b0;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      low_r  <= '0;
      half_r <= 1'b0;
      dout_r <= '0;
      dv_r   <= 1'b0;
    end else begin
      low_r  <= low_nxt;
      half_r <= half_nxt;
      dout_r <= dout_nxt;
      dv_r   <= dv_nxt;
    end
  end
  assign dout       = dout_r;
  assign dout_valid = dv_r;
endmodule

// ### core/rbd_rx_tail.sv
// Receive PCS tail: decoder, byte deserializer, byte ordering, AXI4-Lite registers
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ns
`include "rbd_defines.svh"
module rbd_rx_tail (
  input  wire logic        CLOCK,
  input  wire logic        RST_B,
  input  wire logic [19:0] RX_ALIGNED,
  input  wire logic        RX_ALIGNED_VALID,
  input  wire logic        RX_SYNC_STATUS,
  input  wire logic        RX_ORDER_TRIGGER,
  output logic      [39:0] RX_DATA,
  output logic      [3:0]  RX_CTRL_FLAG,
  output logic             RX_DATA_VALID,
  output logic             RX_ORDER_ALIGNED,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic      [1:0]  S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic      [31:0] S_AXI_RDATA,
  output logic      [1:0]  S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);
  import rbd_pkg::*;
  // Register file
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [31:0] pat_r;
  logic [31:0] pat_nxt;
  logic [31:0] pad_r;
  logic [31:0] pad_nxt;
  logic        aw_got_r;
  logic        aw_got_nxt;
  logic        w_got_r;
  logic        w_got_nxt;
  logic [7:0]  awa_r;
  logic [7:0]  awa_nxt;
  logic [31:0] wd_r;
  logic [31:0] wd_nxt;
  logic [3:0]  ws_r;
  logic [3:0]  ws_nxt;
  logic        bv_r;
  logic        bv_nxt;
  logic [1:0]  br_r;
  logic [1:0]  br_nxt;
  logic        rv_r;
  logic        rv_nxt;
  logic [31:0] rd_r;
  logic [31:0] rd_nxt;
  logic [1:0]  rr_r;
  logic [1:0]  rr_nxt;
  logic        sw_err_r;
  logic        sw_err_nxt;
  function automatic logic [31:0] rbd_strobe(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) res[i*8 +: 8] = nw[i*8 +: 8];
    end
    return res;
  endfunction
  // Synchronisers for pin inputs
  logic sync_m_r;
  logic sync_s_r;
  logic sync_d_r;
  logic trig_m_r;
  logic trig_s_r;
  logic trig_d_r;
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      sync_m_r <= 1'b0;
      sync_s_r <= 1'b0;
      sync_d_r <= 1'b0;
      trig_m_r <= 1'b0;
      trig_s_r <= 1'b0;
      trig_d_r <= 1'b0;
    end else begin
      sync_m_r <= RX_SYNC_STATUS;
      sync_s_r <= sync_m_r;
      sync_d_r <= sync_s_r;
      trig_m_r <= RX_ORDER_TRIGGER;
      trig_s_r <= trig_m_r;
      trig_d_r <= trig_s_r;
    end
  end
  // Configuration decode
  logic dec_en;
  logic dbl;
  logic des_en;
  logic ord_en;
  logic oc48;
  logic ord_legal;
  assign dbl    = ctrl_r[`RBD_CTRL_DOUBLE];
  assign dec_en = ctrl_r[`RBD_CTRL_DEC_EN] & dbl;
  assign oc48   = ctrl_r[`RBD_CTRL_OC48] & ~dbl;
  // Not forced: the 100 MHz core clock is under the 250 MHz fabric ceiling, so the control bit decides
  assign des_en = ctrl_r[`RBD_CTRL_DES_EN] | (`RBD_PCS_MHZ > `RBD_FABRIC_CEIL_MHZ);
  // Unsupported combinations keep the stage bypassed rather than corrupt data
  always_comb begin
    if (!dbl) begin
      ord_legal = oc48 | (ctrl_r[`RBD_CTRL_MANUAL_AL] ^ ctrl_r[`RBD_CTRL_DEC_EN]);
    end else begin
      ord_legal = ctrl_r[`RBD_CTRL_MANUAL_AL];
    end
  end
  assign ord_en = ctrl_r[`RBD_CTRL_ORD_EN] & des_en & ord_legal;
  // Decoder and lane shaping
  logic [15:0] dec_byte;
  logic [1:0]  dec_ctrl;
  rbd_decoder u_dec (
    .code_in  (RX_ALIGNED),
    .byte_out (dec_byte),
    .ctrl_out (dec_ctrl)
  );
  // Each symbol lane is 10 bits: decoded byte with flag in bit 8, or raw code
  logic [19:0] lane_in;
  always_comb begin
    if (dec_en) begin
      lane_in = {1'b0, dec_ctrl[1], dec_byte[15:8], 1'b0, dec_ctrl[0], dec_byte[7:0]};
    end else if (!dbl) begin
      lane_in = {10'h000, RX_ALIGNED[9:0]};
    end else begin
      lane_in = RX_ALIGNED;
    end
  end
  logic [39:0] des_word;
  logic        des_valid;
  logic [39:0] des_pack;
  rbd_deser #(.W(20)) u_des (
    .clock      (CLOCK),
    .rst_b      (RST_B),
    .din        (lane_in),
    .din_valid  (RX_ALIGNED_VALID),
    .enable     (des_en),
    .dout       (des_word),
    .dout_valid (des_valid)
  );
  // Single-width words hold two symbols in lanes 0 and 1
  always_comb begin
    if (dbl || !des_en) begin
      des_pack = des_word;
    end else begin
      des_pack = {20'h0_0000, des_word[29:20], des_word[9:0]};
    end
  end
  // Byte ordering
  logic [9:0] pat_sym;
  logic [9:0] pad_sym;
  logic [9:0] cmp_mask;
  always_comb begin
    if (oc48) begin
      pat_sym = `RBD_OC48_PATTERN;
      pad_sym = `RBD_OC48_PAD;
    end else begin
      pat_sym = pat_r[9:0];
      pad_sym = pad_r[9:0];
    end
    // Decoded lanes, and single lanes with the decode bit set, compare nine bits; OC-48 and raw double ten; other raw single lanes eight
    if (dec_en || (!dbl && ctrl_r[`RBD_CTRL_DEC_EN])) begin
      cmp_mask = 10'h1FF;
    end else if (!dbl && !oc48) begin
      cmp_mask = 10'h0FF;
    end else begin
      cmp_mask = 10'h3FF;
    end
  end
  function automatic logic rbd_match(input logic [9:0] s, input logic [9:0] p, input logic [9:0] m);
    return ((s & m) == (p & m));
  endfunction
  rbd_ord_state_type st_r;
  rbd_ord_state_type st_nxt;
  logic        shift_r;
  logic        shift_nxt;
  logic [19:0] carry_r;
  logic [19:0] carry_nxt;
  logic [39:0] out_r;
  logic [39:0] out_nxt;
  logic        ov_r;
  logic        ov_nxt;
  logic        al_r;
  logic        al_nxt;
  logic        start;
  logic [39:0] sym_word;
  assign start = ctrl_r[`RBD_CTRL_USER_TRIG] ? (trig_s_r & ~trig_d_r)
                                              : (sync_s_r & ~sync_d_r);
  always_comb begin
    st_nxt    = st_r;
    shift_nxt = shift_r;
    carry_nxt = carry_r;
    out_nxt   = out_r;
    ov_nxt    = 1'b0;
    al_nxt    = al_r;
    sym_word  = des_pack;
    if (!ord_en) begin
      st_nxt    = RBD_IDLE_S;
      shift_nxt = 1'b0;
      al_nxt    = 1'b0;
    end else if (start) begin
      st_nxt = RBD_SEARCH_S;
      al_nxt = 1'b0;
    end
    if (des_valid) begin
      ov_nxt = 1'b1;
      if (ord_en && shift_r) begin
        // High half of this word trails into the next one
        sym_word = dbl ? {des_pack[19:0], carry_r} : {20'h0_0000, des_pack[9:0], carry_r[9:0]};
      end
      if (ord_en && st_r == RBD_SEARCH_S && !start) begin
        if (rbd_match(sym_word[9:0], pat_sym, cmp_mask)) begin
          st_nxt = RBD_LOCKED_S;
          al_nxt = 1'b1;
        end else if (rbd_match(dbl ? sym_word[29:20] : sym_word[19:10], pat_sym, cmp_mask)) begin
          // Pattern in high half: pad the low half, keep the high half for later
          sym_word = dbl ? {des_pack[19:0], pad_sym, pad_sym}
                         : {20'h0_0000, des_pack[9:0], pad_sym};
          shift_nxt = ~shift_r;
          st_nxt    = RBD_LOCKED_S;
          al_nxt    = 1'b1;
        end
      end
      carry_nxt = dbl ? des_pack[39:20] : {10'h000, des_pack[19:10]};
      out_nxt   = sym_word;
    end
  end
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      st_r    <= RBD_IDLE_S;
      shift_r <= 1'b0;
      carry_r <= '0;
      out_r   <= '0;
      ov_r    <= 1'b0;
      al_r    <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      shift_r <= shift_nxt;
      carry_r <= carry_nxt;
      out_r   <= out_nxt;
      ov_r    <= ov_nxt;
      al_r    <= al_nxt;
    end
  end
  // Fabric outputs; flags widen with the data
  always_comb begin
    if (dec_en) begin
      RX_DATA      = {8'h00, out_r[37:30], out_r[27:20], out_r[17:10], out_r[7:0]};
      RX_CTRL_FLAG = {out_r[38], out_r[28], out_r[18], out_r[8]};
    end else if (!dbl && ctrl_r[`RBD_CTRL_DEC_EN]) begin
      RX_DATA      = {24'h00_0000, out_r[17:10], out_r[7:0]};
      RX_CTRL_FLAG = {2'b00, out_r[18], out_r[8]};
    end else begin
      RX_DATA      = out_r;
      RX_CTRL_FLAG = 4'h0;
    end
  end
  assign RX_DATA_VALID    = ov_r;
  assign RX_ORDER_ALIGNED = al_r;
  // AXI4-Lite slave
  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    awa_nxt    = awa_r;
    wd_nxt     = wd_r;
    ws_nxt     = ws_r;
    bv_nxt     = bv_r;
    br_nxt     = br_r;
    ctrl_nxt   = ctrl_r;
    pat_nxt    = pat_r;
    pad_nxt    = pad_r;
    sw_err_nxt = sw_err_r;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_got_nxt = 1'b1;
      awa_nxt    = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_got_nxt = 1'b1;
      wd_nxt    = S_AXI_WDATA;
      ws_nxt    = S_AXI_WSTRB;
    end
    if (aw_got_r && w_got_r && !bv_r) begin
      bv_nxt     = 1'b1;
      br_nxt     = 2'b00;
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      unique case ({awa_r[7:2], 2'b00})
        `RBD_REG_CTRL:    ctrl_nxt = rbd_strobe(ctrl_r, wd_r, ws_r) & 32'h0000_007F;
        `RBD_REG_PATTERN: pat_nxt  = rbd_strobe(pat_r, wd_r, ws_r) & 32'h0000_03FF;
        `RBD_REG_PAD:     pad_nxt  = rbd_strobe(pad_r, wd_r, ws_r) & 32'h0000_03FF;
        `RBD_REG_STATUS:  sw_err_nxt = 1'b0;
        default:          br_nxt   = 2'b10;
      endcase
    end
    if (bv_r && S_AXI_BREADY) begin
      bv_nxt = 1'b0;
    end
    // Illegal ordering setup is sticky; set wins over the clear
    if (ctrl_r[`RBD_CTRL_ORD_EN] && !ord_legal) begin
      sw_err_nxt = 1'b1;
    end
  end
  assign S_AXI_AWREADY = ~aw_got_r & ~bv_r;
  assign S_AXI_WREADY  = ~w_got_r & ~bv_r;
  assign S_AXI_BVALID  = bv_r;
  assign S_AXI_BRESP   = br_r;
  always_comb begin
    rv_nxt = rv_r;
    rd_nxt = rd_r;
    rr_nxt = rr_r;
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rv_nxt = 1'b1;
      rr_nxt = 2'b00;
      unique case ({S_AXI_ARADDR[7:2], 2'b00})
        `RBD_REG_CTRL:    rd_nxt = ctrl_r;
        `RBD_REG_PATTERN: rd_nxt = pat_r;
        `RBD_REG_PAD:     rd_nxt = pad_r;
        `RBD_REG_STATUS:  rd_nxt = {28'h000_0000, sw_err_r, shift_r, des_en, al_r};
        default: begin
          rd_nxt = 32'h0000_0000;
          rr_nxt = 2'b10;
        end
      endcase
    end else if (rv_r && S_AXI_RREADY) begin
      rv_nxt = 1'b0;
    end
  end
  assign S_AXI_ARREADY = ~rv_r;
  assign S_AXI_RVALID  = rv_r;
  assign S_AXI_RDATA   = rd_r;
  assign S_AXI_RRESP   = rr_r;
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awa_r    <= 8'h00;
      wd_r     <= 32'h0000_0000;
      ws_r     <= 4'h0;
      bv_r     <= 1'b0;
      br_r     <= 2'b00;
      ctrl_r   <= `RBD_CTRL_RST;
      pat_r    <= `RBD_PATTERN_RST;
      pad_r    <= `RBD_PAD_RST;
      sw_err_r <= 1'b0;
      rv_r     <= 1'b0;
      rd_r     <= 32'h0000_0000;
      rr_r     <= 2'b00;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r  <= w_got_nxt;
      awa_r    <= awa_nxt;
      wd_r     <= wd_nxt;
      ws_r     <= ws_nxt;
      bv_r     <= bv_nxt;
      br_r     <= br_nxt;
      ctrl_r   <= ctrl_nxt;
      pat_r    <= pat_nxt;
      pad_r    <= pad_nxt;
      sw_err_r <= sw_err_nxt;
      rv_r     <= rv_nxt;
      rd_r     <= rd_nxt;
      rr_r     <= rr_nxt;
    end
  end
endmodule

// ### verification/rbd_rx_tail_checker.sv
// Port-level concurrent checks for the receive tail
`timescale 1ns/1ns
module rbd_rx_tail_checker (
  input wire logic        CLOCK,
  input wire logic        RST_B,
  input wire logic        RX_ALIGNED_VALID,
  input wire logic [39:0] RX_DATA,
  input wire logic [3:0]  RX_CTRL_FLAG,
  input wire logic        RX_DATA_VALID,
  input wire logic        RX_ORDER_ALIGNED,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  AST_OUT_LAT: assert property (RX_DATA_VALID |-> $past(RX_ALIGNED_VALID, 2))
    else $error("Output word without an input word two cycles before");
  AST_DATA_HOLD: assert property ($changed(RX_DATA) |-> RX_DATA_VALID)
    else $error("Output data changed without a valid pulse");
  AST_FLAG_HOLD: assert property ($changed(RX_CTRL_FLAG) |-> RX_DATA_VALID)
    else $error("Control flags changed without a valid pulse");
  AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("Write response dropped before handshake");
  AST_B_LAT: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
    else $error("Write response late");
  AST_AW_BLOCK: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("Write accepted while response pending");
  AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("Read data not held until handshake");
  AST_R_LAT: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("Read data late");
  AST_AR_RDY: assert property (S_AXI_ARREADY == !S_AXI_RVALID)
    else $error("Read address ready not the inverse of read valid");
  COV_WORD: cover property (RX_DATA_VALID);
  COV_ALIGN: cover property ($rose(RX_ORDER_ALIGNED));
  COV_WR: cover property (S_AXI_BVALID && S_AXI_BREADY);
endmodule

bind rbd_rx_tail rbd_rx_tail_checker i_rbd_rx_tail_checker (
  .CLOCK(CLOCK), .RST_B(RST_B), .RX_ALIGNED_VALID(RX_ALIGNED_VALID), .RX_DATA(RX_DATA),
  .RX_CTRL_FLAG(RX_CTRL_FLAG), .RX_DATA_VALID(RX_DATA_VALID), .RX_ORDER_ALIGNED(RX_ORDER_ALIGNED),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY)
);

// ### verification/rbd_fabric_model.sv
// Fabric-side user logic: raises the ordering trigger on request
`timescale 1ns/1ns
module rbd_fabric_model (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic start,
  output logic      trig
);
  logic trig_r;
  logic trig_nxt;
  // Level held high, so the design sees one clean rising edge
  always_comb begin
    trig_nxt = start;
  end
  always_ff @(posedge clock) begin
    if (!rst_b) trig_r <= 1'b0;
    else trig_r <= trig_nxt;
  end
  assign trig = trig_r;
endmodule

// ### verification/tb.sv
// Self-checking bench for the receive deserialize and order tail
`timescale 1ns/1ns
module tb;
  logic        clk, rst_b, avalid, sync, go, trig, dvalid, ord_al;
  logic        awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [19:0] aligned, lo, hi;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rdat, seed;
  logic [1:0]  resp, bresp, rresp;
  logic [39:0] rx_data, got;
  logic [39:0] e[4];
  logic [3:0]  flag, lflag;
  logic [39:0] q_d[$];
  logic [3:0]  q_f[$];
  int          error_cnt, n_checks, m, k;
  localparam logic [9:0] KC = 10'h17C;
  localparam logic [9:0] PT = 10'h0A5;
  localparam logic [9:0] PD = 10'h05A;
  rbd_rx_tail i_rbd_rx_tail (
    .CLOCK(clk), .RST_B(rst_b), .RX_ALIGNED(aligned), .RX_ALIGNED_VALID(avalid), .RX_SYNC_STATUS(sync),
    .RX_ORDER_TRIGGER(trig), .RX_DATA(rx_data), .RX_CTRL_FLAG(flag), .RX_DATA_VALID(dvalid),
    .RX_ORDER_ALIGNED(ord_al), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
  );
  rbd_fabric_model i_rbd_fabric_model (.clock(clk), .rst_b(rst_b), .start(go), .trig(trig));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (dvalid === 1'b1) begin
      q_d.push_back(rx_data);
      q_f.push_back(flag);
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Single-width lanes sit in the low 20 bits, first word low
  function automatic logic [39:0] exp_pair(input int dbl, input logic [19:0] l, input logic [19:0] h);
    return dbl ? {h, l} : {20'h0_0000, h[9:0], l[9:0]};
  endfunction
  task automatic stop_test;
    if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic hang(input string nm);
    error_cnt++;
    $display("Error %s expected answer seen timeout", nm);
    stop_test;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (i == 50) hang("write");
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    int i;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (i == 50) hang("read");
    rdat = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic cfg(input logic [7:0] c);
    @(posedge clk);
    rst_b <= 1'b0; avalid <= 1'b0; sync <= 1'b0; go <= 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    q_d.delete();
    q_f.delete();
    wr(8'h00, {24'h00_0000, c});
  endtask
  // Back-to-back words: valid stays high between calls
  task automatic pair(input logic [19:0] l, input logic [19:0] h);
    @(posedge clk);
    aligned <= l; avalid <= 1'b1;
    @(posedge clk);
    aligned <= h;
  endtask
  task automatic idle;
    @(posedge clk);
    avalid <= 1'b0;
  endtask
  task automatic take;
    int i;
    for (i = 0; i < 50 && q_d.size() == 0; i++) @(posedge clk);
    if (q_d.size() == 0) hang("output word");
    got = q_d.pop_front();
    lflag = q_f.pop_front();
  endtask
  task automatic chk_w(input string nm, input logic [9:0] h, input logic [9:0] l);
    take;
    check(nm, 40'(got[19:0]), exp_pair(0, 20'(l), 20'(h)));
  endtask
  initial begin
    rst_b = 1'b0; avalid = 1'b0; sync = 1'b0; go = 1'b0; aligned = '0;
    awaddr = '0; araddr = '0; wdata = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    seed = 32'h1651; error_cnt = 0; n_checks = 0;
    cfg(8'h02);
    for (k = 1; k < 3; k++) begin
      rd(8'(k * 4));
      check("pattern and pad reset", 40'(rdat), 40'h0);
    end
    rd(8'h0C);
    check("deserializer on at reset", 40'(rdat[1]), 40'h1);
    rd(8'h10);
    check("unmapped read resp", 40'(resp), 40'h2);
    wr(8'h14, 32'h0000_0001);
    check("unmapped write resp", 40'(resp), 40'h2);
    for (m = 0; m < 2; m++) begin
      cfg(m ? 8'h0A : 8'h02);
      for (k = 0; k < 4; k++) begin
        seed = xs(seed);
        lo = seed[19:0];
        seed = xs(seed);
        hi = seed[19:0];
        e[k] = exp_pair(m, lo, hi);
        pair(lo, hi);
      end
      idle;
      for (k = 0; k < 4; k++) begin
        take;
        check("paired word", m ? got : 40'(got[19:0]), e[k]);
      end
    end
    cfg(8'h0B);
    pair({10'h2AA, KC}, {KC, KC});
    idle;
    take;
    check("decoded low byte", 40'(got[7:0]), 40'hBC);
    check("decoded upper bytes", 40'(got[31:16]), 40'hBCBC);
    check("decoded flags", 40'(lflag), 40'hD);
    cfg(8'h0A);
    pair({10'h2AA, KC}, {KC, KC});
    idle;
    take;
    check("decoder bypassed", got, {KC, KC, 10'h2AA, KC});
    check("bypass flags", 40'(lflag), 40'h0);
    cfg(8'h00);
    pair(20'h0_0155, 20'h0_00AA);
    idle;
    take;
    check("unpaired word one", 40'(got[9:0]), 40'h155);
    take;
    check("unpaired word two", 40'(got[9:0]), 40'h0AA);
    rd(8'h0C);
    check("deserializer off", 40'(rdat[1]), 40'h0);
    // Pattern sent second so that it lands in the high lane and forces a pad
    cfg(8'h46);
    wr(8'h04, 32'(PT));
    wr(8'h08, 32'(PD));
    sync <= 1'b1;
    repeat (4) @(posedge clk);
    pair(20'h1, 20'(PT));
    pair(20'h2, 20'h3);
    pair(20'h4, 20'h5);
    idle;
    chk_w("pad inserted", 10'h1, PD);
    chk_w("pattern moved low", 10'h2, PT);
    chk_w("carry kept", 10'h4, 10'h3);
    check("aligned after match", 40'(ord_al), 40'h1);
    rd(8'h0C);
    check("status aligned", 40'(rdat[0]), 40'h1);
    check("status shift active", 40'(rdat[2]), 40'h1);
    cfg(8'h26);
    sync <= 1'b1;
    repeat (4) @(posedge clk);
    pair(20'h1, 20'h0_0028);
    pair(20'h2, 20'h3);
    idle;
    chk_w("fixed pad", 10'h1, 10'h028);
    chk_w("fixed pattern low", 10'h2, 10'h028);
    cfg(8'h56);
    wr(8'h04, 32'(PT));
    wr(8'h08, 32'(PD));
    pair(20'h1, 20'(PT));
    idle;
    chk_w("no search before trigger", PT, 10'h1);
    check("not aligned before trigger", 40'(ord_al), 40'h0);
    go <= 1'b1;
    repeat (4) @(posedge clk);
    pair(20'h2, 20'(PT));
    idle;
    chk_w("pad after trigger", 10'h2, PD);
    check("aligned after trigger", 40'(ord_al), 40'h1);
    // Double-width decoded: nine-bit pattern with the control flag on top
    cfg(8'h4F);
    wr(8'h04, 32'h0000_01BC);
    wr(8'h08, 32'(PD));
    sync <= 1'b1;
    repeat (4) @(posedge clk);
    pair({10'h2AA, 10'h2AA}, {10'h2AA, KC});
    idle;
    take;
    check("nine-bit pattern pads", 40'({got[15:0], lflag[1:0]}), 40'({PD[7:0], PD[7:0], 2'b00}));
    check("aligned after nine-bit match", 40'(ord_al), 40'h1);
    for (k = 0; k < 2; k++) begin
      cfg(k ? 8'h0E : 8'h06);
      rd(8'h0C);
      check("illegal ordering flagged", 40'(rdat[3]), 40'h1);
      wr(8'h00, 32'h0000_0002);
      wr(8'h0C, 32'h0000_0000);
      rd(8'h0C);
      check("illegal flag cleared", 40'(rdat[3]), 40'h0);
    end
    stop_test;
  end
endmodule
